//--- logic/cell_monitor_pkg.sv
//--------------------------------------------------------------------
// Summary of operation
// - sda changes only while scl is low
// - start and repeated start detected identically
// - bytes are eight bits, msb first, then acknowledge
// - addressed receiver acknowledges every received byte
// - start condition starts the bus time-out timer
// - scl fall restarts timer, stop halts it
// - time-out returns bus logic idle, registers kept
// - time-out period 32 or 64 ms by trim
// - write: address, register byte, data byte, stop
// - read: write register address, then read data
// - direction bit one reads, zero writes
// - acknowledge only a matching seven-bit address
// - sleep request bit one starts sleep
// - wake flag forces and holds sleep request zero
// - wake input over 10 us sets flag
// - master may write one to wake flag
// - wake flag read shows pin state only
// - monitor enable zero forces output off
// - cell select picks cell code plus one
// - balance bits switch each cell's balance switch
//--------------------------------------------------------------------
`default_nettype none
package cell_monitor_pkg;
   //-----------------------------------------------------------------
   // bus address and register map
   //-----------------------------------------------------------------
   localparam logic [6:0] DEVICE_ADDRESS = 7'h5C;
   localparam logic [7:0] SLEEP_AND_MONITOR_CONTROL = 8'h00;
   localparam logic [7:0] CHARGE_BALANCE_ENABLES = 8'h01;
   localparam logic [7:0] SLEEP_AND_MONITOR_RESET = 8'h00;
   localparam logic [7:0] CHARGE_BALANCE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   //-----------------------------------------------------------------
   // field positions of sleep_and_monitor_control
   //-----------------------------------------------------------------
   localparam int SLEEP_REQUEST_BIT = 7;
   localparam int EXTERNAL_WAKE_BIT = 6;
   localparam int MONITOR_ENABLE_BIT = 5;
   localparam int RESERVED_HI_BIT = 4;
   localparam int RESERVED_LO_BIT = 3;
   localparam int CELL_SELECT_HI_BIT = 2;
   localparam int CELL_SELECT_LO_BIT = 0;
   //-----------------------------------------------------------------
   // timing
   //-----------------------------------------------------------------
   localparam int CLK_KHZ = 50000;
   localparam int WAKE_TIME_US = 10;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_KHZ / 1000;
   localparam int BUS_TIMEOUT_SHORT_MS = 32;
   localparam int BUS_TIMEOUT_LONG_MS = 64;
   localparam int BUS_TIMEOUT_SHORT_CYCLES = BUS_TIMEOUT_SHORT_MS * CLK_KHZ;
   localparam int BUS_TIMEOUT_LONG_CYCLES = BUS_TIMEOUT_LONG_MS * CLK_KHZ;
   localparam int TIMEOUT_WIDTH = 22;
   localparam int WAKE_WIDTH = 10;
   //-----------------------------------------------------------------
   // serial slave states
   //-----------------------------------------------------------------
   typedef enum logic [3:0] {
      st_idle, st_addr, st_addr_ack, st_reg, st_reg_ack,
      st_data, st_data_ack, st_tx, st_tx_ack, st_ignore
   } bus_state_t;
endpackage
`default_nettype wire

//--- logic/cell_monitor_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_i2c_slave #(
   parameter int bus_timeout_short_cycles =
      cell_monitor_pkg::BUS_TIMEOUT_SHORT_CYCLES,
   parameter int bus_timeout_long_cycles =
      cell_monitor_pkg::BUS_TIMEOUT_LONG_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic high_voltage_wake_pin,
   input wire logic timeout_trim_long,
   output logic sleep_request,
   output logic wake_request,
   output logic monitor_enable,
   output logic [2:0] cell_select,
   output logic [7:0] cell_switch_select,
   output logic [7:0] balance_switch_enables
);
   localparam int TW = cell_monitor_pkg::TIMEOUT_WIDTH;
   localparam int WW = cell_monitor_pkg::WAKE_WIDTH;
   localparam logic [TW-1:0] TMO_SHORT_LAST =
      TW'(bus_timeout_short_cycles - 1);
   localparam logic [TW-1:0] TMO_LONG_LAST =
      TW'(bus_timeout_long_cycles - 1);
   localparam logic [WW-1:0] WAKE_LIMIT =
      WW'(cell_monitor_pkg::WAKE_CYCLES);

   //-----------------------------------------------------------------
   // state record
   //-----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] filt;
      cell_monitor_pkg::bus_state_t state;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic rw;
      logic nacked;
      logic [7:0] reg_addr;
      logic sda_drive;
      logic tmo_run;
      logic [TW-1:0] tmo_cnt;
      logic [WW-1:0] wake_cnt;
      logic ext_wake;
      logic wake_sw;
      logic sleep_req;
      logic mon_en;
      logic [1:0] reserved;
      logic [2:0] cell_sel;
      logic [7:0] balance;
      logic [7:0] cell_sw;
   } slave_state_t;

   slave_state_t st;
   slave_state_t next_st;
   logic [3:0] filt_new;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic tmo_expire;
   logic [7:0] read_data;
   logic [TW-1:0] tmo_last;

   //-----------------------------------------------------------------
   // input synchronisers: index 0 scl, 1 sda, 2 wake, 3 trim
   //-----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_filt
         assign filt_new[gi] = (st.s2[gi] == st.s3[gi]) ?
            st.s3[gi] : st.filt[gi];
      end
   endgenerate

   assign scl_rise = filt_new[0] & ~st.filt[0];
   assign scl_fall = ~filt_new[0] & st.filt[0];
   assign start_det = st.filt[0] & filt_new[0] &
      st.filt[1] & ~filt_new[1];
   assign stop_det = st.filt[0] & filt_new[0] &
      ~st.filt[1] & filt_new[1];
   assign tmo_last = st.filt[3] ? TMO_LONG_LAST : TMO_SHORT_LAST;
   assign tmo_expire = st.tmo_run & ~scl_fall & ~stop_det &
      ~start_det & (st.tmo_cnt >= tmo_last);

   //-----------------------------------------------------------------
   // register read mux
   //-----------------------------------------------------------------
   always_comb begin
      case (st.reg_addr)
         cell_monitor_pkg::SLEEP_AND_MONITOR_CONTROL: begin
            read_data = {st.sleep_req, st.ext_wake, st.mon_en,
               st.reserved, st.cell_sel};
         end
         cell_monitor_pkg::CHARGE_BALANCE_ENABLES: begin
            read_data = st.balance;
         end
         default: begin
            read_data = cell_monitor_pkg::UNMAPPED_READ;
         end
      endcase
   end

   //-----------------------------------------------------------------
   // next state
   //-----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.s1 = {timeout_trim_long, high_voltage_wake_pin,
         sda_in, scl_in};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.filt = filt_new;
      // wake detection
      if (filt_new[2]) begin
         if (st.wake_cnt <= WAKE_LIMIT) begin
            next_st.wake_cnt = st.wake_cnt + 1'b1;
         end
      end else begin
         next_st.wake_cnt = '0;
      end
      next_st.ext_wake = filt_new[2] &
         (next_st.wake_cnt > WAKE_LIMIT);
      // time-out timer
      if (st.tmo_run) begin
         if (scl_fall) begin
            next_st.tmo_cnt = '0;
         end else begin
            next_st.tmo_cnt = st.tmo_cnt + 1'b1;
         end
      end
      if (start_det) begin
         next_st.state = cell_monitor_pkg::st_addr;
         next_st.bit_cnt = '0;
         next_st.sda_drive = 1'b0;
         next_st.tmo_run = 1'b1;
         next_st.tmo_cnt = '0;
      end else if (stop_det) begin
         next_st.state = cell_monitor_pkg::st_idle;
         next_st.sda_drive = 1'b0;
         next_st.tmo_run = 1'b0;
         next_st.tmo_cnt = '0;
      end else if (tmo_expire) begin
         next_st.state = cell_monitor_pkg::st_idle;
         next_st.sda_drive = 1'b0;
         next_st.tmo_run = 1'b0;
         next_st.tmo_cnt = '0;
      end else if (scl_rise) begin
         case (st.state)
            cell_monitor_pkg::st_addr,
            cell_monitor_pkg::st_reg,
            cell_monitor_pkg::st_data: begin
               next_st.shreg = {st.shreg[6:0], filt_new[1]};
               next_st.bit_cnt = st.bit_cnt + 1'b1;
            end
            cell_monitor_pkg::st_tx_ack: begin
               next_st.nacked = filt_new[1];
            end
            default: begin
               next_st.nacked = st.nacked;
            end
         endcase
      end else if (scl_fall) begin
         case (st.state)
            cell_monitor_pkg::st_addr: begin
               if (st.bit_cnt == 4'h8) begin
                  if (st.shreg[7:1] ==
                     cell_monitor_pkg::DEVICE_ADDRESS) begin
                     next_st.state = cell_monitor_pkg::st_addr_ack;
                     next_st.sda_drive = 1'b1;
                     next_st.rw = st.shreg[0];
                  end else begin
                     next_st.state = cell_monitor_pkg::st_ignore;
                  end
               end
            end
            cell_monitor_pkg::st_reg: begin
               if (st.bit_cnt == 4'h8) begin
                  next_st.reg_addr = st.shreg;
                  next_st.state = cell_monitor_pkg::st_reg_ack;
                  next_st.sda_drive = 1'b1;
               end
            end
            cell_monitor_pkg::st_data: begin
               if (st.bit_cnt == 4'h8) begin
                  next_st.state = cell_monitor_pkg::st_data_ack;
                  next_st.sda_drive = 1'b1;
                  case (st.reg_addr)
                     cell_monitor_pkg::SLEEP_AND_MONITOR_CONTROL: begin
                        next_st.wake_sw = st.shreg[
                           cell_monitor_pkg::EXTERNAL_WAKE_BIT];
                        next_st.sleep_req = st.shreg[
                           cell_monitor_pkg::SLEEP_REQUEST_BIT] &
                           ~st.ext_wake & ~st.wake_sw;
                        next_st.mon_en = st.shreg[
                           cell_monitor_pkg::MONITOR_ENABLE_BIT];
                        next_st.reserved = st.shreg[
                           cell_monitor_pkg::RESERVED_HI_BIT:
                           cell_monitor_pkg::RESERVED_LO_BIT];
                        next_st.cell_sel = st.shreg[
                           cell_monitor_pkg::CELL_SELECT_HI_BIT:
                           cell_monitor_pkg::CELL_SELECT_LO_BIT];
                     end
                     cell_monitor_pkg::CHARGE_BALANCE_ENABLES: begin
                        next_st.balance = st.shreg;
                     end
                     default: begin
                        next_st.balance = st.balance;
                     end
                  endcase
               end
            end
            cell_monitor_pkg::st_addr_ack,
            cell_monitor_pkg::st_reg_ack,
            cell_monitor_pkg::st_data_ack: begin
               next_st.bit_cnt = '0;
               next_st.sda_drive = 1'b0;
               if (st.state == cell_monitor_pkg::st_addr_ack &&
                  st.rw) begin
                  next_st.state = cell_monitor_pkg::st_tx;
                  next_st.shreg = read_data;
                  next_st.sda_drive = ~read_data[7];
                  next_st.bit_cnt = 4'h1;
               end else if (st.state == cell_monitor_pkg::st_addr_ack) begin
                  next_st.state = cell_monitor_pkg::st_reg;
               end else begin
                  next_st.state = cell_monitor_pkg::st_data;
               end
            end
            cell_monitor_pkg::st_tx: begin
               if (st.bit_cnt == 4'h8) begin
                  next_st.sda_drive = 1'b0;
                  next_st.state = cell_monitor_pkg::st_tx_ack;
               end else begin
                  next_st.shreg = {st.shreg[6:0], 1'b0};
                  next_st.sda_drive = ~st.shreg[6];
                  next_st.bit_cnt = st.bit_cnt + 1'b1;
               end
            end
            cell_monitor_pkg::st_tx_ack: begin
               if (st.nacked) begin
                  next_st.state = cell_monitor_pkg::st_ignore;
               end else begin
                  next_st.state = cell_monitor_pkg::st_tx;
                  next_st.shreg = read_data;
                  next_st.sda_drive = ~read_data[7];
                  next_st.bit_cnt = 4'h1;
               end
            end
            default: begin
               next_st.sda_drive = 1'b0;
            end
         endcase
      end
      if (next_st.ext_wake | next_st.wake_sw) begin
         next_st.sleep_req = 1'b0;
      end
      next_st.cell_sw = next_st.mon_en ? (8'h01 << next_st.cell_sel) : 8'h00;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   //-----------------------------------------------------------------
   // outputs
   //-----------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe = st.sda_drive;
   assign sleep_request = st.sleep_req;
   assign wake_request = st.ext_wake | st.wake_sw;
   assign monitor_enable = st.mon_en;
   assign cell_select = st.cell_sel;
   assign cell_switch_select = st.cell_sw;
   assign balance_switch_enables = st.balance;

   //-----------------------------------------------------------------
   // checks
   //-----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_addr_ack_match: assert property (
      (scl_fall && st.state == cell_monitor_pkg::st_addr &&
       st.bit_cnt == 4'h8 && !start_det && !stop_det && !tmo_expire) |=>
      (sda_oe == ($past(st.shreg[7:1]) == cell_monitor_pkg::DEVICE_ADDRESS)))
      else $error("address acknowledge wrong");
   chk_sda_stable_high: assert property (
      (st.filt[0] && $past(st.filt[0]) && !$past(start_det) &&
       !$past(stop_det) && !$past(tmo_expire)) |-> $stable(sda_oe))
      else $error("sda changed while scl high");
   chk_start_arms_timer: assert property (
      start_det |=> (st.tmo_run && st.tmo_cnt == '0 &&
       st.state == cell_monitor_pkg::st_addr))
      else $error("start did not arm timer");
   chk_fall_restarts: assert property (
      (scl_fall && st.tmo_run && !stop_det) |=> st.tmo_cnt == '0)
      else $error("scl fall did not restart timer");
   chk_stop_halts_timer: assert property (
      (stop_det && !start_det) |=> ##[0:3] !st.tmo_run)
      else $error("stop did not halt timer");
   chk_timeout_idle: assert property (
      tmo_expire |=> (st.state == cell_monitor_pkg::st_idle &&
       !sda_oe && $stable(st.balance) && $stable(st.cell_sel)))
      else $error("time-out did not return idle");
   chk_wake_blocks_sleep: assert property (
      wake_request |-> !sleep_request)
      else $error("sleep request under wake");
   chk_wake_set_delay: assert property (
      (st.wake_cnt == WAKE_LIMIT && filt_new[2]) |=> st.ext_wake)
      else $error("wake flag not set after filter time");
   chk_wake_clear_now: assert property (
      !filt_new[2] |=> !st.ext_wake)
      else $error("wake flag did not clear");
   chk_monitor_off: assert property (
      !monitor_enable |-> cell_switch_select == 8'h00)
      else $error("cell switch on while monitor off");

   cov_register_write: cover property (
      st.state == cell_monitor_pkg::st_data_ack && scl_fall);
   cov_register_read: cover property (
      st.state == cell_monitor_pkg::st_tx_ack && scl_fall);
   cov_bus_timeout: cover property (tmo_expire);
   cov_pin_wake: cover property (!st.ext_wake ##1 st.ext_wake);
endmodule
`default_nettype wire

//--- sim/bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// two-wire bus master, scl stands high when idle
// ---------------------------------------------
module bus_master_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda_line
);
   localparam int q = 40;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // one bit: data set in low phase, sampled late in high phase
   task automatic bit_io(input logic v, output logic r);
      #q sda_low = ~v;
      #q scl = 1'b1;
      #70 r = sda_line;
      #10 scl = 1'b0;
   endtask
   // start and repeated start alike
   task automatic start();
      #(q + 3) sda_low = 1'b0;
      #(4 * q) scl = 1'b1;
      #(2 * q) sda_low = 1'b1;
      #(2 * q) scl = 1'b0;
   endtask
   task automatic stop();
      #q sda_low = 1'b1;
      #(4 * q) scl = 1'b1;
      #(2 * q) sda_low = 1'b0;
      #(2 * q);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(~ack, r);
   endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int to_short = 2000;
   localparam int to_long = 4000;
   localparam logic [7:0] dev_wr = {cell_monitor_pkg::DEVICE_ADDRESS, 1'b0};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic wake_pin = 1'b0;
   logic trim_long = 1'b0;
   logic scl, m_low, sda_out, sda_oe, sda_line;
   logic sleep_request, wake_request, monitor_enable;
   logic [2:0] cell_select;
   logic [7:0] cell_switch_select, balance_switch_enables;
   int err_total = 0;
   int checks_done = 0;
   always #10 clk = ~clk;
   // open drain data line with pull-up
   assign sda_line = (m_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
   bus_master_model m (.scl(scl), .sda_low(m_low), .sda_line(sda_line));
   cell_monitor_i2c_slave #(
      .bus_timeout_short_cycles(to_short),
      .bus_timeout_long_cycles(to_long)
   ) dut (
      .clk(clk),
      .reset_n(reset_n),
      .scl_in(scl),
      .sda_in(sda_line),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .high_voltage_wake_pin(wake_pin),
      .timeout_trim_long(trim_long),
      .sleep_request(sleep_request),
      .wake_request(wake_request),
      .monitor_enable(monitor_enable),
      .cell_select(cell_select),
      .cell_switch_select(cell_switch_select),
      .balance_switch_enables(balance_switch_enables)
   );
   // ---------------------------------------------
   // compare and bus tasks
   // ---------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] d);
      logic a0, a1, a2;
      m.start();
      m.send(dev_wr, a0);
      m.send(ra, a1);
      m.send(d, a2);
      m.stop();
      chk1(a0 & a1 & a2, 1'b1);
      wait_clk(8);
   endtask
   task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
      logic a0, a1, a2;
      logic [7:0] d;
      m.start();
      m.send(dev_wr, a0);
      m.send(ra, a1);
      m.start();
      m.send(dev_wr | 8'h01, a2);
      m.recv(1'b0, d);
      m.stop();
      chk1(a0 & a1 & a2, 1'b1);
      chk8(d, exp);
      wait_clk(8);
   endtask
   // stall the bus with the device holding its acknowledge
   task automatic to_case(input logic t, input int hold);
      logic a;
      @(negedge clk) trim_long = t;
      m.start();
      m.send(dev_wr, a);
      for (int i = 7; i >= 0; i--) m.bit_io(i == 0, a);
      wait_clk(hold - 100);
      chk1(sda_oe, 1'b1);
      wait_clk(200);
      chk1(sda_oe, 1'b0);
      m.stop();
      wait_clk(8);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // test sequence
   // ---------------------------------------------
   initial begin
      logic a;
      wait_clk(2);
      reset_n = 1'b1;
      wait_clk(10);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      for (int k = 0; k < 8; k++) begin
         wr(8'h00, 8'h20 | k[7:0]);
         chk8(cell_switch_select, 8'h01 << k);
         chk8({5'h00, cell_select}, k[7:0]);
         chk1(monitor_enable, 1'b1);
      end
      wr(8'h00, 8'h1F);
      chk8(cell_switch_select, 8'h00);
      rd(8'h00, 8'h1F);
      wr(8'h01, 8'hA5);
      chk8(balance_switch_enables, 8'hA5);
      wr(8'h02, 8'hFF);
      rd(8'h02, 8'h00);
      rd(8'h01, 8'hA5);
      m.start();
      m.send(8'hA0, a);
      m.stop();
      chk1(a, 1'b0);
      wr(8'h00, 8'h80);
      chk1(sleep_request, 1'b1);
      rd(8'h00, 8'h80);
      wake_pin = 1'b1;
      wait_clk(400);
      wake_pin = 1'b0;
      wait_clk(10);
      chk1(wake_request, 1'b0);
      wake_pin = 1'b1;
      wait_clk(520);
      chk1(wake_request, 1'b1);
      chk1(sleep_request, 1'b0);
      rd(8'h00, 8'h40);
      wr(8'h00, 8'h80);
      chk1(sleep_request, 1'b0);
      wake_pin = 1'b0;
      wait_clk(10);
      chk1(wake_request, 1'b0);
      wr(8'h00, 8'h40);
      chk1(wake_request, 1'b1);
      rd(8'h00, 8'h00);
      wr(8'h00, 8'h80);
      chk1(sleep_request, 1'b0);
      wr(8'h00, 8'h00);
      chk1(wake_request, 1'b0);
      wr(8'h00, 8'h80);
      chk1(sleep_request, 1'b1);
      to_case(1'b0, to_short);
      rd(8'h01, 8'hA5);
      to_case(1'b1, to_long);
      rd(8'h00, 8'h80);
      give_verdict();
   end
   initial begin
      #1_000_000;
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
